// ### hdl/boot_pkg.sv
package boot_pkg;
   // boot-time values loaded into the serial engine's control state
   localparam logic [31:0] CTL_BOOT_VALUE    = 32'h0000_5d06;
   localparam logic [15:0] BAUD_BOOT_VALUE   = 16'h0064;
   localparam logic [15:0] SSEL_BOOT_VALUE   = 16'hfe01;
   localparam logic [31:0] DMAC_BOOT_VALUE   = 32'h0000_0007;
   localparam logic [31:0] INDEX_BOOT_VALUE  = 32'h0008_0000;
   localparam logic [31:0] MODIFY_BOOT_VALUE = 32'h0000_0001;
   localparam logic [31:0] COUNT_BOOT_VALUE  = 32'h0000_0180;
   // control field positions
   localparam int          WL_LSB            = 0;
   localparam logic [1:0]  WL_32BIT          = 2'h2;
   localparam int          CLOCK_PHASE_BIT_POS        = 10;
   localparam int          CPOL_POS          = 11;
   localparam int          HIGH_BIT_FIRST_ORDER_POS          = 5;
   // boot strap code and command word
   localparam logic [1:0]  BOOT_MASTER_CODE  = 2'h1;
   localparam logic [7:0]  READ_OPCODE_HIGH_BIT_FIRST_ORDER  = 8'h03;
   localparam logic [23:0] READ_ADDRESS      = 24'h000000;
   localparam logic [5:0]  WORD_BITS         = 6'h20;
   // serial clock = core clock / (4 * divider); half period in core cycles
   localparam logic [9:0]  HALF_PERIOD       = 10'(2 * BAUD_BOOT_VALUE);
   localparam int          ADDR_W            = 20;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0]       data;
   } mem_word_t;
endpackage : boot_pkg

// ### hdl/spi_master_boot_loader.sv
`timescale 1ns/1ns
module spi_master_boot_loader (
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   input  wire logic [1:0]           boot_select_pins,
   output logic                      serial_clock_pin,
   output logic                      mosi,
   input  wire logic                 miso,
   output logic                      flag_pin_zero_o,
   output logic                      flag_pin_zero_oe,
   output logic                      mem_valid,
   input  wire logic                 mem_ready,
   output boot_pkg::mem_word_t       mem_word,
   output logic                      dma_done_irq,
   output logic                      boot_busy,
   output logic [31:0]               serial_control_register,
   output logic [15:0]               serial_baud_divider,
   output logic [15:0]               slave_select_flag_register,
   output logic [31:0]               serial_dma_control,
   output logic [31:0]               dma_index_pointer,
   output logic [31:0]               dma_modifier,
   output logic [31:0]               dma_word_count
);
   import boot_pkg::*;

   typedef enum logic [1:0] {IDLE, CMD, DATA, DONE} state_t;

   // sequencer and strap
   state_t          state_q;
   logic            strap_seen_q;
   // clock divider and shift engine
   logic [9:0]      div_q;
   logic            sclk_q;
   logic [5:0]      bit_q;
   logic [31:0]     tx_q;
   logic [31:0]     rx_q;
   logic            push;
   logic            buf_ready;
   logic            tick;
   logic            lead;
   logic            word_end;
   // two-entry buffer toward memory and check helpers
   mem_word_t       buf_q [2];
   logic [1:0]      cnt_q;
   logic            rd_q;
   logic            wr_q;
   logic            stall;
   logic [9:0]      hold_q;

   // command word, opcode first and sent high bit first, address sent low bit first
   // built from the package constants, so it is fixed at elaboration
   function automatic logic [31:0] cmd_word();
      logic [7:0] op;
      for (int i = 0; i < 8; i++) begin
         op[i] = READ_OPCODE_HIGH_BIT_FIRST_ORDER[7-i];
      end
      // low byte holds the reversed opcode, so 0x03 leaves high bit first
      return {READ_ADDRESS, op};
   endfunction : cmd_word

   // sample the strap once after reset release; async reset takes constants only
   // a later strap change cannot restart a boot that has already run
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         strap_seen_q <= 1'b0;
      end else begin
         strap_seen_q <= 1'b1;
      end
   end

   // control state loaded with the fixed boot values at reset
   // no write path: software may only read them during the load
   // held in flops so the mode cannot move in mid-transfer
   // the engine below is hard-wired to the same mode these bits encode
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         serial_control_register    <= CTL_BOOT_VALUE;
         serial_baud_divider        <= BAUD_BOOT_VALUE;
         slave_select_flag_register <= SSEL_BOOT_VALUE;
         serial_dma_control         <= DMAC_BOOT_VALUE;
      end else begin
         serial_control_register    <= serial_control_register;
         serial_baud_divider        <= serial_baud_divider;
         slave_select_flag_register <= slave_select_flag_register;
         serial_dma_control         <= serial_dma_control;
      end
   end

   // sequencer: strap check, command word, data words, done
   // the command word always takes one full 32-bit word
   // a strap other than master boot leaves the block idle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= IDLE;
      end else begin
         case (state_q)
            // leave idle only on the master boot strap
            IDLE: begin
               if (!strap_seen_q && boot_select_pins == BOOT_MASTER_CODE) begin
                  state_q <= CMD;
               end
            end
            // command word goes out while the answer is dropped
            CMD: begin
               if (word_end) begin
                  state_q <= DATA;
               end
            end
            // last push ends the kernel load
            DATA: begin
               if (push && dma_word_count == 32'h1) begin
                  state_q <= DONE;
               end
            end
            // parked until the next reset
            DONE:    state_q <= DONE;
            default: state_q <= IDLE;
         endcase
      end
   end

   assign boot_busy = (state_q == CMD) || (state_q == DATA);

   // stall: hold the clock high before a new word while the buffer is full,
   // so a slow receiver never loses a word and no bit is cut in half
   assign stall = (bit_q == 6'h0) && sclk_q && !buf_ready && (state_q == DATA);

   // divider; one tick per half period of the serial clock
   assign tick = boot_busy && (div_q == HALF_PERIOD - 10'h1);
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= 10'h0;
      end else if (!boot_busy || tick) begin
         div_q <= 10'h0;
      end else if (!stall) begin
         div_q <= div_q + 10'h1;
      end
   end

   // falling edge launches, rising edge samples (idle high, phase 1)
   // the first fall comes a half period after select, so bit 0 is set up
   // a stall parks the clock high between words, never within one
   assign lead     = tick && sclk_q;
   assign word_end = tick && !sclk_q && (bit_q == WORD_BITS - 6'h1);
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_q <= 1'b1;
      end else if (tick) begin
         sclk_q <= ~sclk_q;
      end else if (!boot_busy) begin
         sclk_q <= 1'b1;
      end
   end
   assign serial_clock_pin = sclk_q;

   // slave select low for the whole boot
   // drive always on: the pin is a dedicated select during boot
   // select falls with busy, a half period before the first clock edge
   assign flag_pin_zero_o  = ~boot_busy;
   assign flag_pin_zero_oe = 1'b1;

   // shift engine, low bit first both ways
   // idle reloads the command so a restart after reset sends it again
   // mosi idles high before the first fall; the slave ignores it then
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bit_q <= 6'h0;
         tx_q  <= 32'h0;
         rx_q  <= 32'h0;
         mosi  <= 1'b1;
      end else if (state_q == IDLE) begin
         tx_q <= cmd_word();
         bit_q <= 6'h0;
      end else if (lead) begin
         mosi <= (state_q == CMD) ? tx_q[0] : 1'b0; // send zeros after command
         tx_q <= {1'b0, tx_q[31:1]};
      end else if (tick) begin
         rx_q  <= {miso, rx_q[31:1]};
         bit_q <= (bit_q == WORD_BITS - 6'h1) ? 6'h0 : bit_q + 6'h1;
      end
   end

   // the answer to the command is only filler from the slave
   // nothing of it reaches memory or the buffer
   // command-time word never pushed; data from cycle 32 on
   assign push = word_end && (state_q == DATA);

   // dma address and count
   // both step on the push itself, so the stored address is the old index
   // the index walks internal memory one word at a time
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dma_index_pointer <= INDEX_BOOT_VALUE;
         dma_modifier      <= MODIFY_BOOT_VALUE;
         dma_word_count    <= COUNT_BOOT_VALUE;
      end else if (push) begin
         dma_index_pointer <= dma_index_pointer + dma_modifier;
         dma_word_count    <= dma_word_count - 32'h1;
      end
   end

   // done interrupt level once the count runs out
   // sticky: there is no clear, only a reset ends it
   // only raised when the completion interrupt enable is set
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dma_done_irq <= 1'b0;
      end else if (state_q == DONE && serial_dma_control[2]) begin
         dma_done_irq <= 1'b1;
      end
   end

   // two-entry buffer toward memory
   // one pointer bit each side; count of 2 means full
   // push and pop may fall in one cycle, the count then holds
   assign buf_ready = (cnt_q != 2'h2);
   assign mem_valid = (cnt_q != 2'h0);
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 2'h0;
         rd_q  <= 1'b0;
         wr_q  <= 1'b0;
      end else begin
         if (push && buf_ready) begin
            wr_q <= ~wr_q;
         end
         if (mem_valid && mem_ready) begin
            rd_q <= ~rd_q;
         end
         cnt_q <= cnt_q + 2'(push && buf_ready) - 2'(mem_valid && mem_ready);
      end
   end
   // storage has no reset; valid comes from the count alone
   // the last bit is taken straight from the pin, rx_q shifts on the same edge
   always_ff @(posedge sys_clk) begin
      if (push && buf_ready) begin
         buf_q[wr_q] <= '{addr: dma_index_pointer[ADDR_W-1:0], data: {miso, rx_q[31:1]}};
      end
   end
   assign mem_word = buf_q[rd_q];

   // helper for the checks below: cycles since the clock last moved
   // cleared by a stall too, so only running half periods are measured
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         hold_q <= 10'h0;
      end else if (tick || stall || !boot_busy) begin
         hold_q <= 10'h0;
      end else begin
         hold_q <= hold_q + 10'h1;
      end
   end

   // checks on pins: idle level, select, clock and data timing
   sclk_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !boot_busy |-> serial_clock_pin) else $error("clock not idle high");
   ssel_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      boot_busy |-> !flag_pin_zero_o) else $error("select not low");

   // select stays high while the sequencer sits idle before a boot
   sel_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_q == IDLE |-> flag_pin_zero_o) else $error("select low while idle");

   // the clock only moves on a divider tick
   sclk_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      boot_busy && !tick |=> $stable(serial_clock_pin)) else $error("clock moved off tick");

   // data changes only at a falling edge, so it is stable when sampled
   mosi_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      boot_busy && !lead |=> $stable(mosi)) else $error("data moved off falling edge");

   // the first word starts from idle high with the bit count at zero
   first_launch_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(state_q == CMD) |-> serial_clock_pin && bit_q == 6'h0) else $error("bad start");

   // only zeros go out after the command
   zeros_out_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_q == DATA && lead |=> !mosi) else $error("data sent after command");

   // divider range and exact half period length
   div_range_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      div_q < HALF_PERIOD) else $error("divider out of range");
   half_len_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      tick |-> hold_q == HALF_PERIOD - 10'h1) else $error("half period length");

   // command word: content, length and the dropped answer
   cmd_first_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(state_q == CMD) |-> tx_q == 32'h000000c0) else $error("bad command");
   no_cmd_push_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_q == CMD |-> !push) else $error("command word stored");
   cmd_len_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_q == CMD && word_end |=> state_q == DATA) else $error("command length");

   // fixed boot setup never moves during the load
   word_len_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      serial_control_register[1:0] == WL_32BIT) else $error("word length");
   ctl_fixed_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      $stable(serial_control_register) && $stable(serial_dma_control))
      else $error("boot setup moved");
   modifier_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      dma_modifier == MODIFY_BOOT_VALUE) else $error("modifier moved");
   start_regs_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(state_q == CMD) |-> dma_index_pointer == INDEX_BOOT_VALUE
         && dma_word_count == COUNT_BOOT_VALUE) else $error("dma setup at start");

   // dma stepping and the end of the load
   count_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      push |=> dma_word_count == $past(dma_word_count) - 32'h1) else $error("count");
   index_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      push |=> dma_index_pointer == $past(dma_index_pointer) + 32'h1) else $error("index");
   done_count_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_q == DONE |-> dma_word_count == 32'h0) else $error("done before count ran out");
   done_irq_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_q == DONE |-> ##[1:2] dma_done_irq) else $error("no done irq");
   stop_rx_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_q == DONE |-> !push) else $error("push after done");

   // buffer: no push into a full buffer, offered word stands until taken
   buf_push_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      push |-> buf_ready) else $error("push into full buffer");
   word_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      mem_valid && !mem_ready |=> mem_valid && $stable(mem_word)) else $error("word dropped");
endmodule : spi_master_boot_loader

// ### tb/flash_model.sv
`timescale 1ns/1ns
module flash_model (
   input  wire logic        sys_clk,
   input  wire logic        sclk,
   input  wire logic        sel_n,
   input  wire logic        mosi,
   input  wire logic [1:0]  mode,
   output logic             miso,
   output logic [31:0]      cmd_word
);
   int   n_rise = 0;
   int   n_fall = 0;
   logic drive = 1'b0;
   logic bit_q = 1'b0;
   // filler byte ahead of the kernel; value is arbitrary
   localparam logic [7:0] PAD_BYTE = 8'ha5;
   // first falling edge on which each kind of slave drives its image
   function automatic int first_fall(input logic [1:0] m);
      case (m)
         2'h1:    first_fall = 24; // prom: 16-bit address, one pad byte
         2'h2:    first_fall = 0;  // host: every clock, four pad bytes
         default: first_fall = 32; // flash: silent until command ends
      endcase
   endfunction : first_fall
   // stream word k is 5a0f3c00 plus k, sent low bit first
   function automatic logic pattern(input int b);
      logic [31:0] w;
      w = 32'h5a0f_3c00 | 32'(b / 32);
      pattern = w[b % 32];
   endfunction : pattern
   // command captured low bit first on rising edges
   always @(posedge sclk or posedge sel_n) begin
      if (sel_n) begin
         n_rise <= 0;
      end else begin
         if (n_rise < 32) cmd_word[n_rise] <= mosi;
         n_rise <= n_rise + 1;
      end
   end
   // silent before the mode's first falling edge, pad bytes until bit 32, then data from bit 32 on
   always @(negedge sclk or posedge sel_n) begin
      if (sel_n) begin
         n_fall <= 0;
         drive  <= 1'b0;
      end else begin
         if (n_fall >= first_fall(mode)) begin
            drive <= 1'b1;
            bit_q <= (n_fall < 32) ? PAD_BYTE[n_fall % 8] : pattern(n_fall - 32);
         end
         n_fall <= n_fall + 1;
      end
   end
   // undriven line toggles so a stale bit never looks valid
   always @(posedge sys_clk) miso <= drive ? bit_q : ~miso;
   initial miso = 1'b0;
endmodule : flash_model

// ### tb/spi_master_boot_loader_bench.sv
`timescale 1ns/1ns
module spi_master_boot_loader_bench;
   import boot_pkg::*;
   logic        sys_clk, rstn, sclk, mosi, miso, sel, sel_oe, valid, ready, irq, busy;
   logic [1:0]  strap, pad_mode;
   logic [15:0] baud, ssel;
   logic [31:0] ctl, dmac, idx, mdf, cnt, cmd;
   mem_word_t   word;
   logic [31:0] got [7];
   logic [31:0] rows [7] = '{32'h5d06, 32'h64, 32'hfe01, 32'h7, 32'h80000, 32'h1, 32'h180};
   int          n_fail = 0, num_checks = 0, i, k;
   spi_master_boot_loader spi_master_boot_loader_inst (.sys_clk(sys_clk), .rstn(rstn),
      .boot_select_pins(strap), .serial_clock_pin(sclk), .mosi(mosi), .miso(miso),
      .flag_pin_zero_o(sel), .flag_pin_zero_oe(sel_oe), .mem_valid(valid), .mem_ready(ready),
      .mem_word(word), .dma_done_irq(irq), .boot_busy(busy), .serial_control_register(ctl),
      .serial_baud_divider(baud), .slave_select_flag_register(ssel),
      .serial_dma_control(dmac), .dma_index_pointer(idx), .dma_modifier(mdf),
      .dma_word_count(cnt));
   flash_model flash_model_inst (.sys_clk(sys_clk), .sclk(sclk), .sel_n(sel), .mosi(mosi),
      .mode(pad_mode), .miso(miso), .cmd_word(cmd));
   always_comb got = '{ctl, 32'(baud), 32'(ssel), dmac, idx, mdf, cnt};
   task automatic cmp_bit(input logic g, input logic e, input string m);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : cmp_bit
   task automatic cmp_vec(input logic [31:0] g, input logic [31:0] e, input string m);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : cmp_vec
   // bounded wait for a buffered word, then take it in one cycle
   task automatic take(input int n);
      int b;
      ready = 1'b1;
      for (b = 0; b < 20000 && valid !== 1'b1; b++) @(negedge sys_clk);
      cmp_bit(valid, 1'b1, "no word");
      cmp_vec(32'(word.addr), 32'h80000 + n, "address");
      cmp_vec(word.data, 32'h5a0f_3c00 | n, "data");
      @(negedge sys_clk);
   endtask : take
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      rstn = 1'b0;
      strap = 2'h0;
      pad_mode = 2'h0;
      ready = 1'b0;
      repeat (12) @(negedge sys_clk);
      cmp_bit(sclk, 1'b1, "clock idle");
      cmp_bit(valid | irq, 1'b0, "reset outputs");
      rstn = 1'b1;
      repeat (20) @(negedge sys_clk);
      cmp_bit(busy, 1'b0, "wrong strap boots");
      cmp_bit(sel, 1'b1, "select moved");
      $display("strap test done");
      rstn = 1'b0;
      strap = 2'h1;
      repeat (12) @(negedge sys_clk);
      for (i = 0; i < 7; i++) cmp_vec(got[i], rows[i], "reset value");
      cmp_vec(32'(ctl[WL_LSB+:2]), 32'(WL_32BIT), "word length");
      cmp_bit(ctl[CPOL_POS] & ctl[CLOCK_PHASE_BIT_POS] & ~ctl[HIGH_BIT_FIRST_ORDER_POS], 1'b1, "mode");
      rstn = 1'b1;
      repeat (3) @(negedge sys_clk);
      cmp_bit(sel | ~sel_oe | ~busy, 1'b0, "select not low");
      for (k = 0; k < 1000 && sclk !== 1'b0; k++) @(negedge sys_clk);
      for (k = 0; k < 1000 && sclk !== 1'b1; k++) @(negedge sys_clk);
      cmp_vec(k, 200, "half period");
      for (k = 0; k < 30000 && valid !== 1'b1; k++) @(negedge sys_clk);
      cmp_bit(valid, 1'b1, "no first word");
      cmp_vec(cmd, 32'h0000_00c0, "command");
      $display("command test done");
      // receiver stalls: two words fill the buffer, clock must park high
      repeat (14000) @(negedge sys_clk);
      k = 0;
      repeat (2000) begin
         @(negedge sys_clk);
         k += (sclk !== 1'b1);
      end
      cmp_vec(k, 0, "clock ran while full");
      for (i = 0; i < 3; i++) take(i);
      ready = 1'b0;
      cmp_bit(irq, 1'b0, "early done");
      $display("stream test done");
      // mid-run reset; a host slave drives pad bytes during the command
      rstn = 1'b0;
      pad_mode = 2'h2;
      repeat (12) @(negedge sys_clk);
      cmp_bit(busy | valid, 1'b0, "reset mid-run");
      rstn = 1'b1;
      for (k = 0; k < 30000 && valid !== 1'b1; k++) @(negedge sys_clk);
      take(0);
      ready = 1'b0;
      $display("host pad test done");
      results();
   end
endmodule : spi_master_boot_loader_bench
